// ===== hw/auth_link_consts.svh
/*
  constant set for the command link: status codes, block lengths, opcodes, crc polynomial, defaults.
  assumes nothing; included only by the package, the design files use its macros.
*/
`ifndef AUTH_LINK_CONSTS_SVH
`define AUTH_LINK_CONSTS_SVH
`define CRC_POLY 16'h8005
`define CRC_INIT 16'h0000
`define ST_OK 8'h00
`define ST_MISCMP 8'h01
`define ST_PARSE 8'h03
`define ST_EXEC 8'h0f
`define ST_WAKE 8'h11
`define ST_COMM 8'hff
`define BLK_STATUS_LEN 8'h04
`define BLK_MIN_FRAME 8'h04
`define BLK_MIN_CMD 8'h07
`define BLK_DATA_CMD 8'h0b
`define POS_OPCODE 1
`define POS_PARAM1 2
`define POS_DATA 5
`define OPC_CHECKMAC 8'h28
`define OPC_NONCE 8'h16
`define OPC_READ 8'h02
`define OPC_PAUSE 8'h01
`define OPC_REV 8'h30
`define CHECKMAC_COPY_BIT 0
`define WATCHDOG_CYCLES_DEF 1000000
`define EXEC_CYCLES_DEF 16
`define FIFO_DEPTH_DEF 8
`define RX_DEPTH_DEF 16
`endif

// ===== hw/auth_link_pkg.sv
/*
  shared types and the crc step of the command link.
  assumes auth_link_consts.svh is on the include path.
*/
`include "auth_link_consts.svh"
package auth_link_pkg;
  typedef enum logic [2:0] {DEV_SLEEP, DEV_AWAKE, DEV_EXEC, DEV_RESP, DEV_IDLE} dev_state_t;
  typedef enum logic [1:0] {HOST_IDLE, HOST_SEND, HOST_WAIT, HOST_READ} host_state_t;
  typedef logic [15:0] crc_t;

  // one byte into the crc, least significant bit first
  function automatic crc_t crc_step(input crc_t crc, input logic [7:0] data);
    crc_t c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (data[i] ^ c[15]) begin
        c = {c[14:0], 1'b0} ^ `CRC_POLY;
      end else begin
        c = {c[14:0], 1'b0};
      end
    end
    return c;
  endfunction
endpackage

// ===== hw/auth_link_if.sv
/*
  byte-level command link between host controller and device.
  assumes both ends on one clock; bit-level serial framing lives outside.
*/
`timescale 1ns/10ps
interface auth_link_if;
  logic wake;
  logic sleepReq;
  logic idleReq;
  logic startStop;
  logic hValid;
  logic hReady;
  logic [7:0] hData;
  logic dValid;
  logic dReady;
  logic [7:0] dData;
  logic busy;
  modport device (input wake, sleepReq, idleReq, startStop, hValid, hData, dReady,
                  output hReady, dValid, dData, busy);
  modport host (output wake, sleepReq, idleReq, startStop, hValid, hData, dReady,
                input hReady, dValid, dData, busy);
endinterface

// ===== hw/byte_fifo.sv
/*
  flip-flop fifo with valid/ready on both sides and a synchronous flush.
  assumes DEPTH is a power of two.
*/
`timescale 1ns/10ps
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `FIFO_DEPTH_DEF
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW:0] wrPtr_reg;
  logic [AW:0] rdPtr_reg;
  logic push;
  logic pop;

  assign outValid = wrPtr_reg != rdPtr_reg;
  assign inReady = !((wrPtr_reg[AW] != rdPtr_reg[AW]) && (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]));
  assign push = inValid && inReady && !flush;
  assign pop = outValid && outReady && !flush;
  assign outData = mem_reg[rdPtr_reg[AW-1:0]];

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else if (flush) begin
      wrPtr_reg <= '0;
      rdPtr_reg <= '0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + 1'b1;
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_reg[wrPtr_reg[AW-1:0]] <= inData;
    end
  end
endmodule

// ===== hw/auth_device_end.sv
/*
  device end: block receiver with crc check, status engine, shared output buffer,
  sleep/idle/wake power states and a watchdog that forces sleep.
  assumes the link is driven by logic on the same clock, one byte per handshake.
*/
`timescale 1ns/10ps
module auth_device_end #(
  parameter int WATCHDOG_CYCLES = `WATCHDOG_CYCLES_DEF,
  parameter int EXEC_CYCLES = `EXEC_CYCLES_DEF,
  parameter int RX_DEPTH = `RX_DEPTH_DEF,
  parameter int FIFO_DEPTH = `FIFO_DEPTH_DEF
) (
  input wire logic clock,
  input wire logic rstn,
  auth_link_if.device link,
  output logic asleep,
  output logic idling,
  output logic digestValid,
  output logic [7:0] lastStatus
);
  auth_link_pkg::dev_state_t state_reg;
  logic [31:0] wdCount_reg;
  logic [7:0] rxBuf_reg [RX_DEPTH];
  logic [7:0] rxIdx_reg;
  logic [7:0] rxCount_reg;
  logic [7:0] rxCrcLo_reg;
  auth_link_pkg::crc_t rxCrc_reg;
  logic crcOk_reg;
  logic [15:0] execCount_reg;
  logic [7:0] respCode_reg;
  logic [1:0] respIdx_reg;
  logic [31:0] scratch_digest_reg;
  logic [31:0] seed_reg;
  logic digestValid_reg;
  logic digestCopy_reg;
  logic [7:0] lastStatus_reg;

  logic awake;
  logic wdExpire;
  logic enterSleep;
  logic enterIdle;
  logic wakeEvt;
  logic accept;
  logic rxLast;
  logic [7:0] status;
  logic [7:0] opcode;
  logic [31:0] rxData;
  auth_link_pkg::crc_t respCrc;
  logic [7:0] respByte;
  logic fifoInReady;
  logic fifoOutValid;
  logic fifoFlush;
  logic readOpen;

  // required count for an opcode; zero marks an unknown opcode
  function automatic logic [7:0] req_len(input logic [7:0] op);
    unique case (op)
      `OPC_CHECKMAC, `OPC_NONCE: req_len = `BLK_DATA_CMD;
      `OPC_READ, `OPC_PAUSE, `OPC_REV: req_len = `BLK_MIN_CMD;
      default: req_len = 8'h00;
    endcase
  endfunction

  assign awake = state_reg inside {auth_link_pkg::DEV_AWAKE, auth_link_pkg::DEV_EXEC, auth_link_pkg::DEV_RESP};
  assign wdExpire = awake && (wdCount_reg == 32'(WATCHDOG_CYCLES - 1));
  assign enterSleep = wdExpire || (state_reg == auth_link_pkg::DEV_AWAKE && link.sleepReq);
  assign enterIdle = !wdExpire && state_reg == auth_link_pkg::DEV_AWAKE && !link.sleepReq && link.idleReq;
  assign wakeEvt = link.wake && (state_reg == auth_link_pkg::DEV_SLEEP || state_reg == auth_link_pkg::DEV_IDLE);
  // receiving only while awake and not busy; busy ignores the link
  assign link.hReady = state_reg == auth_link_pkg::DEV_AWAKE && !link.sleepReq && !link.idleReq;
  assign link.busy = state_reg == auth_link_pkg::DEV_EXEC || state_reg == auth_link_pkg::DEV_RESP;
  assign accept = link.hValid && link.hReady && !wdExpire && !link.startStop;
  // a count below the smallest frame ends the block at once
  assign rxLast = (rxIdx_reg == 8'h00) ? (link.hData < `BLK_MIN_FRAME) : (rxIdx_reg == rxCount_reg - 8'h01);

  assign opcode = rxBuf_reg[`POS_OPCODE];
  assign rxData = {rxBuf_reg[`POS_DATA+3], rxBuf_reg[`POS_DATA+2], rxBuf_reg[`POS_DATA+1], rxBuf_reg[`POS_DATA]};

  // crc fault first; parse checked before execution, either order is allowed
  always_comb begin
    if (!crcOk_reg || rxCount_reg < `BLK_MIN_FRAME || rxCount_reg > 8'(RX_DEPTH)) begin
      status = `ST_COMM;
    end else if (req_len(opcode) == 8'h00 || rxCount_reg < req_len(opcode)
                 || (opcode == `OPC_CHECKMAC && rxCount_reg != req_len(opcode))) begin
      status = `ST_PARSE;
    end else if (opcode == `OPC_CHECKMAC && !digestValid_reg) begin
      status = `ST_EXEC;
    end else if (opcode == `OPC_CHECKMAC && rxData != scratch_digest_reg) begin
      status = `ST_MISCMP;
    end else begin
      status = `ST_OK;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= auth_link_pkg::DEV_SLEEP;
    end else if (enterSleep) begin
      state_reg <= auth_link_pkg::DEV_SLEEP;
    end else begin
      unique case (state_reg)
        auth_link_pkg::DEV_SLEEP, auth_link_pkg::DEV_IDLE: begin
          if (link.wake) begin
            state_reg <= auth_link_pkg::DEV_RESP;
          end
        end
        auth_link_pkg::DEV_AWAKE: begin
          if (enterIdle) begin
            state_reg <= auth_link_pkg::DEV_IDLE;
          end else if (accept && rxLast) begin
            state_reg <= auth_link_pkg::DEV_EXEC;
          end
        end
        auth_link_pkg::DEV_EXEC: begin
          if (execCount_reg == 16'(EXEC_CYCLES - 1)) begin
            state_reg <= auth_link_pkg::DEV_RESP;
          end
        end
        auth_link_pkg::DEV_RESP: begin
          if (fifoInReady && respIdx_reg == 2'd3) begin
            state_reg <= auth_link_pkg::DEV_AWAKE;
          end
        end
      endcase
    end
  end

  // no command touches this counter; only a wake restarts it
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wdCount_reg <= '0;
    end else if (wakeEvt) begin
      wdCount_reg <= '0;
    end else if (awake) begin
      wdCount_reg <= wdCount_reg + 32'd1;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxIdx_reg <= '0;
      rxCount_reg <= '0;
      rxCrc_reg <= `CRC_INIT;
      rxCrcLo_reg <= '0;
      crcOk_reg <= 1'b0;
    end else if (enterSleep || enterIdle || wakeEvt || (link.startStop && state_reg == auth_link_pkg::DEV_AWAKE)) begin
      rxIdx_reg <= '0;
    end else if (accept) begin
      rxIdx_reg <= rxLast ? 8'h00 : rxIdx_reg + 8'h01;
      if (rxIdx_reg == 8'h00) begin
        rxCount_reg <= link.hData;
        rxCrc_reg <= auth_link_pkg::crc_step(`CRC_INIT, link.hData);
        crcOk_reg <= 1'b0;
      end else if (rxIdx_reg < rxCount_reg - 8'h02) begin
        rxCrc_reg <= auth_link_pkg::crc_step(rxCrc_reg, link.hData);
      end else if (!rxLast) begin
        rxCrcLo_reg <= link.hData;
      end else begin
        crcOk_reg <= rxCrc_reg == {link.hData, rxCrcLo_reg};
      end
    end
  end

  // surplus bytes beyond the buffer are dropped, the crc still covers them
  always_ff @(posedge clock) begin
    if (accept && rxIdx_reg < 8'(RX_DEPTH)) begin
      rxBuf_reg[rxIdx_reg[$clog2(RX_DEPTH)-1:0]] <= link.hData;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      execCount_reg <= '0;
    end else if (state_reg == auth_link_pkg::DEV_EXEC) begin
      execCount_reg <= execCount_reg + 16'd1;
    end else begin
      execCount_reg <= '0;
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      respCode_reg <= `ST_WAKE;
      respIdx_reg <= '0;
      lastStatus_reg <= '0;
    end else if (wakeEvt) begin
      respCode_reg <= `ST_WAKE;
      respIdx_reg <= '0;
    end else if (state_reg == auth_link_pkg::DEV_EXEC && execCount_reg == 16'(EXEC_CYCLES - 1)) begin
      respCode_reg <= status;
      lastStatus_reg <= status;
      respIdx_reg <= '0;
    end else if (state_reg == auth_link_pkg::DEV_RESP && fifoInReady) begin
      respIdx_reg <= respIdx_reg + 2'd1;
    end
  end

  // scratch state: cleared by sleep, kept by idle except a copied digest
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      scratch_digest_reg <= '0;
      seed_reg <= '0;
      digestValid_reg <= 1'b0;
      digestCopy_reg <= 1'b0;
    end else if (enterSleep) begin
      scratch_digest_reg <= '0;
      seed_reg <= '0;
      digestValid_reg <= 1'b0;
      digestCopy_reg <= 1'b0;
    end else if (enterIdle) begin
      if (digestCopy_reg) begin
        scratch_digest_reg <= '0;
        digestValid_reg <= 1'b0;
        digestCopy_reg <= 1'b0;
      end
    end else if (state_reg == auth_link_pkg::DEV_EXEC && execCount_reg == 16'(EXEC_CYCLES - 1) && status == `ST_OK) begin
      if (opcode == `OPC_NONCE) begin
        scratch_digest_reg <= rxData ^ seed_reg;
        seed_reg <= {seed_reg[30:0], seed_reg[31]} ^ rxData;
        digestValid_reg <= 1'b1;
        digestCopy_reg <= 1'b0;
      end else if (opcode == `OPC_CHECKMAC && rxBuf_reg[`POS_PARAM1][`CHECKMAC_COPY_BIT]) begin
        digestCopy_reg <= 1'b1;
      end
    end
  end

  assign respCrc = auth_link_pkg::crc_step(auth_link_pkg::crc_step(`CRC_INIT, `BLK_STATUS_LEN), respCode_reg);
  always_comb begin
    unique case (respIdx_reg)
      2'd0: respByte = `BLK_STATUS_LEN;
      2'd1: respByte = respCode_reg;
      2'd2: respByte = respCrc[7:0];
      2'd3: respByte = respCrc[15:8];
    endcase
  end

  // a new block, a wake or a sleep discards whatever answer was waiting
  assign fifoFlush = enterSleep || wakeEvt || (accept && rxIdx_reg == 8'h00);
  // reads stay closed while a block is half sent or the device is busy
  assign readOpen = state_reg == auth_link_pkg::DEV_AWAKE && rxIdx_reg == 8'h00;
  assign link.dValid = fifoOutValid && readOpen;

  byte_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) outBuf (
    .clock(clock),
    .rstn(rstn),
    .flush(fifoFlush),
    .inValid(state_reg == auth_link_pkg::DEV_RESP),
    .inReady(fifoInReady),
    .inData(respByte),
    .outValid(fifoOutValid),
    .outReady(link.dReady && readOpen),
    .outData(link.dData)
  );

  assign asleep = state_reg == auth_link_pkg::DEV_SLEEP;
  assign idling = state_reg == auth_link_pkg::DEV_IDLE;
  assign digestValid = digestValid_reg;
  assign lastStatus = lastStatus_reg;
endmodule

// ===== hw/auth_host_end.sv
/*
  host end: wake/sleep/idle sequences, command block builder with crc,
  response reader with crc check and one resend on a communication error.
  assumes the device end on the same clock through auth_link_if.
*/
`timescale 1ns/10ps
module auth_host_end (
  input wire logic clock,
  input wire logic rstn,
  auth_link_if.host link,
  input wire logic wakeReq,
  input wire logic sleepReq,
  input wire logic idleReq,
  input wire logic abortReq,
  input wire logic opValid,
  output logic opReady,
  input wire logic [7:0] opCode,
  input wire logic [7:0] opParam1,
  input wire logic [15:0] opParam2,
  input wire logic [31:0] opData,
  input wire logic opHasData,
  output logic rspValid,
  output logic [7:0] rspCount,
  output logic [7:0] rspStatus,
  output logic rspCrcOk
);
  auth_link_pkg::host_state_t state_reg;
  logic [7:0] txIdx_reg;
  logic [7:0] txLen_reg;
  logic [7:0] txOp_reg;
  logic [7:0] txP1_reg;
  logic [15:0] txP2_reg;
  logic [31:0] txData_reg;
  auth_link_pkg::crc_t txCrc_reg;
  logic retried_reg;
  logic [7:0] rxIdx_reg;
  logic [7:0] rxLo_reg;
  auth_link_pkg::crc_t rxCrc_reg;
  logic rspValid_reg;
  logic [7:0] rspCount_reg;
  logic [7:0] rspStatus_reg;
  logic rspCrcOk_reg;
  logic [7:0] txByte;
  logic txFire;
  logic rxFire;
  logic rxEnd;
  logic quiet;

  assign quiet = state_reg == auth_link_pkg::HOST_IDLE && !link.busy;
  // sleep and idle only go out while the host is idle and the device is not busy
  assign link.sleepReq = quiet && sleepReq;
  assign link.idleReq = quiet && !sleepReq && idleReq;
  assign link.wake = state_reg == auth_link_pkg::HOST_IDLE && wakeReq;
  assign link.startStop = abortReq && state_reg == auth_link_pkg::HOST_SEND;
  assign opReady = quiet && !sleepReq && !idleReq && !wakeReq;

  always_comb begin
    if (txIdx_reg == 8'h00) begin
      txByte = txLen_reg;
    end else if (txIdx_reg == txLen_reg - 8'h02) begin
      txByte = txCrc_reg[7:0];
    end else if (txIdx_reg == txLen_reg - 8'h01) begin
      txByte = txCrc_reg[15:8];
    end else begin
      unique case (txIdx_reg)
        8'h01: txByte = txOp_reg;
        8'h02: txByte = txP1_reg;
        8'h03: txByte = txP2_reg[7:0];
        8'h04: txByte = txP2_reg[15:8];
        8'h05: txByte = txData_reg[7:0];
        8'h06: txByte = txData_reg[15:8];
        8'h07: txByte = txData_reg[23:16];
        default: txByte = txData_reg[31:24];
      endcase
    end
  end

  assign link.hValid = state_reg == auth_link_pkg::HOST_SEND && !abortReq;
  assign link.hData = txByte;
  assign txFire = link.hValid && link.hReady;
  // reading only in HOST_READ, once the whole block is out or after a wake
  assign link.dReady = state_reg == auth_link_pkg::HOST_READ;
  assign rxFire = link.dValid && link.dReady;
  assign rxEnd = rxFire && rxIdx_reg != 8'h00 && rxIdx_reg == rspCount_reg - 8'h01;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_reg <= auth_link_pkg::HOST_IDLE;
      txIdx_reg <= '0;
      txLen_reg <= `BLK_MIN_CMD;
      txOp_reg <= '0;
      txP1_reg <= '0;
      txP2_reg <= '0;
      txData_reg <= '0;
      txCrc_reg <= `CRC_INIT;
      retried_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        auth_link_pkg::HOST_IDLE: begin
          if (link.wake) begin
            state_reg <= auth_link_pkg::HOST_WAIT;
          end else if (opValid && opReady) begin
            state_reg <= auth_link_pkg::HOST_SEND;
            txIdx_reg <= '0;
            txLen_reg <= opHasData ? `BLK_DATA_CMD : `BLK_MIN_CMD;
            txOp_reg <= opCode;
            txP1_reg <= opParam1;
            txP2_reg <= opParam2;
            txData_reg <= opData;
            txCrc_reg <= `CRC_INIT;
            retried_reg <= 1'b0;
          end
        end
        auth_link_pkg::HOST_SEND: begin
          if (abortReq) begin
            state_reg <= auth_link_pkg::HOST_IDLE;
          end else if (txFire) begin
            txIdx_reg <= txIdx_reg + 8'h01;
            if (txIdx_reg < txLen_reg - 8'h02) begin
              txCrc_reg <= auth_link_pkg::crc_step(txCrc_reg, txByte);
            end
            if (txIdx_reg == txLen_reg - 8'h01) begin
              state_reg <= auth_link_pkg::HOST_WAIT;
            end
          end
        end
        auth_link_pkg::HOST_WAIT: begin
          if (link.dValid) begin
            state_reg <= auth_link_pkg::HOST_READ;
          end
        end
        auth_link_pkg::HOST_READ: begin
          if (rxEnd) begin
            // one resend after a communication error, then give up
            if (!retried_reg && rspStatus_reg == `ST_COMM && txOp_reg != 8'h00) begin
              state_reg <= auth_link_pkg::HOST_SEND;
              txIdx_reg <= '0;
              txCrc_reg <= `CRC_INIT;
              retried_reg <= 1'b1;
            end else begin
              state_reg <= auth_link_pkg::HOST_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rxIdx_reg <= '0;
      rxLo_reg <= '0;
      rxCrc_reg <= `CRC_INIT;
      rspValid_reg <= 1'b0;
      rspCount_reg <= '0;
      rspStatus_reg <= '0;
      rspCrcOk_reg <= 1'b0;
    end else begin
      rspValid_reg <= rxEnd;
      if (rxFire) begin
        rxIdx_reg <= rxEnd ? 8'h00 : rxIdx_reg + 8'h01;
        if (rxIdx_reg == 8'h00) begin
          rspCount_reg <= link.dData;
          rxCrc_reg <= auth_link_pkg::crc_step(`CRC_INIT, link.dData);
        end else if (rxIdx_reg < rspCount_reg - 8'h02) begin
          rxCrc_reg <= auth_link_pkg::crc_step(rxCrc_reg, link.dData);
          if (rxIdx_reg == 8'h01) begin
            rspStatus_reg <= link.dData;
          end
        end else if (!rxEnd) begin
          rxLo_reg <= link.dData;
        end else begin
          rspCrcOk_reg <= rxCrc_reg == {link.dData, rxLo_reg};
        end
      end
    end
  end

  assign rspValid = rspValid_reg;
  assign rspCount = rspCount_reg;
  assign rspStatus = rspStatus_reg;
  assign rspCrcOk = rspCrcOk_reg;
endmodule

// ===== sim/auth_link_assertions.sv
/*
  checker for the byte link between host end and device end.
  assumes it watches the shared link interface on the one clock.
*/
`timescale 1ns/10ps
module auth_link_assertions #(
  parameter int WATCHDOG_CYCLES = 1000000,
  parameter int EXEC_CYCLES = 16
) (
  input wire logic clock,
  input wire logic rstn,
  input wire logic wake,
  input wire logic sleepReq,
  input wire logic idleReq,
  input wire logic startStop,
  input wire logic hValid,
  input wire logic hReady,
  input wire logic [7:0] hData,
  input wire logic dValid,
  input wire logic dReady,
  input wire logic [7:0] dData,
  input wire logic busy
);
  logic lastByte;
  logic cmdFlag;
  logic armed;
  logic [7:0] idx;
  logic [7:0] cnt;
  logic [1:0] rIdx;
  int busyLen;
  int wdCnt;
  assign lastByte = hValid && hReady && idx != 8'h00 && idx == cnt - 8'h01;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      idx <= 8'h00;
      cnt <= 8'h00;
    end else if (startStop || sleepReq || idleReq || wake) begin
      idx <= 8'h00;
    end else if (hValid && hReady) begin
      idx <= lastByte ? 8'h00 : idx + 8'h01;
      cnt <= (idx == 8'h00) ? hData : cnt;
    end
  end
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      busyLen <= 0;
      cmdFlag <= 1'b0;
      rIdx <= 2'h0;
    end else begin
      busyLen <= busy ? busyLen + 1 : 0;
      cmdFlag <= lastByte ? 1'b1 : (wake ? 1'b0 : cmdFlag);
      rIdx <= (busy || sleepReq || hValid) ? 2'h0 : rIdx + 2'(dValid && dReady);
    end
  end
  // a wake that the device ignores restarts this count too, which only makes the check later
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wdCnt <= 0;
      armed <= 1'b0;
    end else if (wake) begin
      wdCnt <= 0;
      armed <= 1'b1;
    end else begin
      armed <= ((sleepReq || idleReq) && !busy) ? 1'b0 : armed;
      wdCnt <= (wdCnt < WATCHDOG_CYCLES + 8) ? wdCnt + 1 : wdCnt;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_last; lastByte; endsequence
  sequence s_quiet; !hReady && !dValid; endsequence
  property p_cmd_busy; s_last |=> busy; endproperty
  a_cmd_busy: assert property (p_cmd_busy) else $error("no busy after block");
  property p_busy_len; $fell(busy) |-> busyLen == (cmdFlag ? EXEC_CYCLES + 4 : 4) && dValid; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length or answer wrong");
  property p_rd_busy; busy |-> !dValid; endproperty
  a_rd_busy: assert property (p_rd_busy) else $error("answer while busy");
  property p_wr_busy; busy |-> !hReady; endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("byte taken while busy");
  property p_first_byte; dValid && dReady && rIdx == 2'h0 |-> dData == 8'h04; endproperty
  a_first_byte: assert property (p_first_byte) else $error("answer count wrong");
  property p_sleep; sleepReq && !busy && !wake |=> s_quiet; endproperty
  a_sleep: assert property (p_sleep) else $error("active after sleep");
  property p_idle; idleReq && !sleepReq && !busy && !wake |=> s_quiet [*2]; endproperty
  a_idle: assert property (p_idle) else $error("active after idle");
  property p_watchdog; armed && wdCnt >= WATCHDOG_CYCLES + 2 |-> s_quiet and !busy; endproperty
  a_watchdog: assert property (p_watchdog) else $error("awake past watchdog");
endmodule

// ===== sim/auth_block_status_power_ctrl_tb.sv
/*
  testbench: host end and device end joined by one link, host user side driven by tasks.
  assumes the design files compiled before it; clock of 125 MHz.
*/
`timescale 1ns/10ps
module auth_block_status_power_ctrl_tb;
  localparam int WD = 400;
  localparam int EX = 2;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic wakeReq = 1'b0, sleepReq = 1'b0, idleReq = 1'b0, opValid = 1'b0, opHasData = 1'b0, abortReq = 1'b0;
  logic [7:0] opCode = 8'h00, opParam1 = 8'h00;
  logic [31:0] opData = 32'h0;
  logic opReady, rspValid, rspCrcOk, asleep, idling, digestValid;
  logic [7:0] rspCount, rspStatus, lastStatus, st0, st1;
  int err_total = 0;
  int comparisons = 0;
  auth_link_if linkIf ();
  auth_device_end #(.WATCHDOG_CYCLES(WD), .EXEC_CYCLES(EX)) auth_device_end_i (.clock(clock), .rstn(rstn),
    .link(linkIf.device), .asleep(asleep), .idling(idling), .digestValid(digestValid), .lastStatus(lastStatus));
  auth_host_end auth_host_end_i (.clock(clock), .rstn(rstn), .link(linkIf.host), .wakeReq(wakeReq),
    .sleepReq(sleepReq), .idleReq(idleReq), .abortReq(abortReq), .opValid(opValid), .opReady(opReady),
    .opCode(opCode), .opParam1(opParam1), .opParam2(16'h0000), .opData(opData), .opHasData(opHasData),
    .rspValid(rspValid), .rspCount(rspCount), .rspStatus(rspStatus), .rspCrcOk(rspCrcOk));
  auth_link_assertions #(.WATCHDOG_CYCLES(WD), .EXEC_CYCLES(EX)) auth_link_assertions_i (.clock(clock),
    .rstn(rstn), .wake(linkIf.wake), .sleepReq(linkIf.sleepReq), .idleReq(linkIf.idleReq),
    .startStop(linkIf.startStop), .hValid(linkIf.hValid), .hReady(linkIf.hReady), .hData(linkIf.hData),
    .dValid(linkIf.dValid), .dReady(linkIf.dReady), .dData(linkIf.dData), .busy(linkIf.busy));
  initial begin
    forever #4 clock = ~clock;
  end
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // results are sampled 1 ns after the edge so that the edge's updates have landed
  task automatic waitRsp(output logic [7:0] st);
    int n;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (rspValid !== 1'b1 && n < 200);
    check({7'h00, rspValid}, 8'h01);
    check(rspCount, 8'h04);
    check({7'h00, rspCrcOk}, 8'h01);
    st = rspStatus;
  endtask
  task automatic pulse(input logic w, input logic s, input logic i);
    @(posedge clock);
    wakeReq <= w;
    sleepReq <= s;
    idleReq <= i;
    @(posedge clock);
    wakeReq <= 1'b0;
    sleepReq <= 1'b0;
    idleReq <= 1'b0;
    @(posedge clock);
    #1;
  endtask
  task automatic doOp(input logic [7:0] code, input logic [7:0] p1, input logic [31:0] data, output logic [7:0] st);
    int n;
    @(posedge clock);
    opCode <= code;
    opParam1 <= p1;
    opData <= data;
    opHasData <= (code == 8'h28 || code == 8'h16);
    opValid <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (opReady !== 1'b1 && n < 100);
    opValid <= 1'b0;
    waitRsp(st);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    pulse(1'b1, 1'b0, 1'b0);
    waitRsp(st0);
    check(st0, 8'h11);
    doOp(8'h55, 8'h00, 32'h0, st0);
    check(st0, 8'h03);
    check(lastStatus, 8'h03);
    doOp(8'h28, 8'h00, 32'h1234abcd, st0);
    check(st0, 8'h0f);
    doOp(8'h16, 8'h00, 32'h1234abcd, st0);
    check(st0, 8'h00);
    doOp(8'h02, 8'h00, 32'h0, st0);
    check(st0, 8'h00);
    doOp(8'h30, 8'h00, 32'h0, st0);
    check(st0, 8'h00);
    // seed is zero after reset, so the digest equals the nonce data
    doOp(8'h28, 8'h00, 32'h5a5a0ff0, st0);
    check(st0, 8'h01);
    doOp(8'h28, 8'h00, 32'h1234abcd, st1);
    check(st1, 8'h00);
    // a block cut by a start/stop must leave no bytes behind for the next one
    @(posedge clock);
    opCode <= 8'h30;
    opHasData <= 1'b0;
    opValid <= 1'b1;
    @(posedge clock);
    opValid <= 1'b0;
    repeat (3) @(posedge clock);
    abortReq <= 1'b1;
    @(posedge clock);
    abortReq <= 1'b0;
    doOp(8'h02, 8'h00, 32'h0, st0);
    check(st0, 8'h00);
    pulse(1'b0, 1'b0, 1'b1);
    check({6'h00, idling, digestValid}, 8'h03);
    pulse(1'b1, 1'b0, 1'b0);
    waitRsp(st0);
    check({7'h00, digestValid}, 8'h01);
    pulse(1'b0, 1'b1, 1'b0);
    check({6'h00, asleep, digestValid}, 8'h02);
    pulse(1'b1, 1'b0, 1'b0);
    waitRsp(st0);
    check(st0, 8'h11);
    doOp(8'h16, 8'h00, 32'h0badf00d, st0);
    doOp(8'h28, 8'h01, 32'h0badf00d, st0);
    check(st0, 8'h00);
    pulse(1'b0, 1'b0, 1'b1);
    check({6'h00, idling, digestValid}, 8'h02);
    pulse(1'b1, 1'b0, 1'b0);
    waitRsp(st0);
    check(st0, 8'h11);
    // the wake from idle must have restarted the watchdog
    repeat (WD - 16) @(posedge clock);
    #1;
    check({7'h00, asleep}, 8'h00);
    repeat (16) @(posedge clock);
    #1;
    check({7'h00, asleep}, 8'h01);
    stop_test();
  end
  initial begin
    #100000;
    err_total++;
    stop_test();
  end
endmodule
